// File: pkg/tap_params.svh
// Constants for the boundary scan test port: widths, opcodes, reset values, timing
`ifndef TAP_PARAMS_SVH
`define TAP_PARAMS_SVH
`define IR_WIDTH        3
`define ID_WIDTH        32
`define BSR_WIDTH       16
`define IR_CAPTURE_LOW  2'h1
// Opcode decode table; encodings are not fixed by the memory, change here only
`define OP_EXTEST       3'h0
`define OP_IDCODE       3'h1
`define OP_SAMPLE_Z     3'h2
`define OP_RSVD_A       3'h3
`define OP_SAMPLE       3'h4
`define OP_RSVD_B       3'h5
`define OP_RSVD_C       3'h6
`define OP_BYPASS       3'h7
// Identification code, value is arbitrary
`define ID_CODE         32'h1234_5001
`define RESET_TMS_EDGES 5
`define TCK_DIV_HALF    4'h4
`define TCK_DIV_W       4
`endif

// File: pkg/tap_pkg.sv
// Types shared by both ends of the boundary scan test port
package tap_pkg;
    typedef enum logic [15:0] {
        ST_RESET      = 16'h0001,
        ST_IDLE       = 16'h0002,
        ST_SEL_DR     = 16'h0004,
        ST_CAP_DR     = 16'h0008,
        ST_SHIFT_DR   = 16'h0010,
        ST_EXIT1_DR   = 16'h0020,
        ST_PAUSE_DR   = 16'h0040,
        ST_EXIT2_DR   = 16'h0080,
        ST_UPD_DR     = 16'h0100,
        ST_SEL_IR     = 16'h0200,
        ST_CAP_IR     = 16'h0400,
        ST_SHIFT_IR   = 16'h0800,
        ST_EXIT1_IR   = 16'h1000,
        ST_PAUSE_IR   = 16'h2000,
        ST_EXIT2_IR   = 16'h4000,
        ST_UPD_IR     = 16'h8000
    } tap_state_t;

    typedef enum logic [2:0] {
        PATH_IR   = 3'h1,
        PATH_BYP  = 3'h2,
        PATH_ID   = 3'h4
    } scan_path_t;

    typedef enum logic [3:0] {
        HC_IDLE   = 4'h1,
        HC_SHIFT  = 4'h2,
        HC_DONE   = 4'h4,
        HC_TLR    = 4'h8
    } host_state_t;
endpackage

// File: pkg/tap_if.sv
// Scan port wires between the memory's test port and the external controller
`timescale 1ns/10ps
interface tap_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo_o;
    logic tdo_oe;
    logic tdo;
    // Undriven output floats; model the pull-up as a high read
    assign tdo = tdo_oe ? tdo_o : 1'b1;

    modport dev  (input tck, input tms, input tdi, output tdo_o, output tdo_oe);
    modport host (output tck, output tms, output tdi, input tdo);
endinterface

// File: rtl/sram_boundary_scan_tap.sv
// Test access port of the memory: controller, instruction, bypass, id and boundary registers
`timescale 1ns/10ps
`include "tap_params.svh"
module sram_boundary_scan_tap
    import tap_pkg::*;
(
    // Memory side clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Pins captured by the boundary register
    input  wire logic [`BSR_WIDTH-1:0] ring_pins,
    // Scan port
    tap_if.dev                         jtag,
    // Memory output control, in the memory clock domain
    output logic                       mem_out_hiz
);
    //////////////////////////////////////////////////////////////////////
    tap_state_t               state_r, state_nxt;
    logic [`IR_WIDTH-1:0]     ir_sh_r, ir_sh_nxt;
    logic [`IR_WIDTH-1:0]     ir_r, ir_nxt;
    logic                     byp_r, byp_nxt;
    logic [`ID_WIDTH-1:0]     dr_r, dr_nxt;
    logic                     tdo_r, tdo_nxt;
    logic                     oe_r, oe_nxt;
    logic                     tms_in, tdi_in;
    logic [1:0]               hiz_sync_r;
    logic [`BSR_WIDTH-1:0]    ring_s1_r, ring_s2_r;

    // pull-up model, an open input reads high
    assign tms_in = (jtag.tms !== 1'b0);
    assign tdi_in = (jtag.tdi !== 1'b0);

    // full decode of the opcode table, reserved codes fall to bypass
    function automatic scan_path_t path_of(input logic [`IR_WIDTH-1:0] op);
        case (op)
            `OP_IDCODE:  path_of = PATH_ID;
            `OP_EXTEST,
            `OP_SAMPLE_Z,
            `OP_SAMPLE:  path_of = PATH_ID;
            default:     path_of = PATH_BYP;
        endcase
    endfunction

    function automatic logic is_bsr(input logic [`IR_WIDTH-1:0] op);
        is_bsr = (op == `OP_EXTEST) || (op == `OP_SAMPLE_Z) || (op == `OP_SAMPLE);
    endfunction

    //////////////////////////////////////////////////////////////////////
    // controller next state
    always_comb begin
        unique case (state_r)
            ST_RESET:    state_nxt = tms_in ? ST_RESET    : ST_IDLE;
            ST_IDLE:     state_nxt = tms_in ? ST_SEL_DR   : ST_IDLE;
            ST_SEL_DR:   state_nxt = tms_in ? ST_SEL_IR   : ST_CAP_DR;
            ST_CAP_DR:   state_nxt = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_nxt = tms_in ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_nxt = tms_in ? ST_UPD_DR   : ST_PAUSE_DR;
            ST_PAUSE_DR: state_nxt = tms_in ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_nxt = tms_in ? ST_UPD_DR   : ST_SHIFT_DR;
            ST_UPD_DR:   state_nxt = tms_in ? ST_SEL_DR   : ST_IDLE;
            // a fifth high edge from any state lands here
            ST_SEL_IR:   state_nxt = tms_in ? ST_RESET    : ST_CAP_IR;
            ST_CAP_IR:   state_nxt = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_nxt = tms_in ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_nxt = tms_in ? ST_UPD_IR   : ST_PAUSE_IR;
            ST_PAUSE_IR: state_nxt = tms_in ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_nxt = tms_in ? ST_UPD_IR   : ST_SHIFT_IR;
            ST_UPD_IR:   state_nxt = tms_in ? ST_SEL_DR   : ST_IDLE;
            default:     state_nxt = ST_RESET;
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Scan registers, rising edge side
    always_comb begin
        ir_sh_nxt = ir_sh_r;
        ir_nxt    = ir_r;
        byp_nxt   = byp_r;
        dr_nxt    = dr_r;
        unique case (state_r)
            ST_CAP_IR:   ir_sh_nxt = {ir_r[`IR_WIDTH-1:2], `IR_CAPTURE_LOW};
            ST_SHIFT_IR: ir_sh_nxt = {tdi_in, ir_sh_r[`IR_WIDTH-1:1]};
            ST_UPD_IR:   ir_nxt = ir_sh_r;
            ST_CAP_DR: begin
                if (ir_r == `OP_IDCODE) begin
                    dr_nxt = `ID_CODE;
                end else if (is_bsr(ir_r)) begin
                    dr_nxt = {{(`ID_WIDTH-`BSR_WIDTH){1'b0}}, ring_s2_r};
                end
                byp_nxt = 1'b0;
            end
            ST_SHIFT_DR: begin
                // one path, input at MSB of that path
                if (path_of(ir_r) == PATH_BYP) begin
                    byp_nxt = tdi_in;
                end else if (is_bsr(ir_r)) begin
                    dr_nxt = {{(`ID_WIDTH-`BSR_WIDTH){1'b0}}, tdi_in, dr_r[`BSR_WIDTH-1:1]};
                end else begin
                    dr_nxt = {tdi_in, dr_r[`ID_WIDTH-1:1]};
                end
            end
            // update stage has no preload and no effect
            default: ;
        endcase
        // any entry into reset presets identification, so five edges suffice
        if (state_nxt == ST_RESET) begin
            ir_nxt = `OP_IDCODE;
        end
    end

    // Pins belong to the memory clock; they must hold two test clocks before Capture-DR
    always_ff @(posedge jtag.tck or posedge rst) begin
        if (rst) begin
            ring_s1_r <= '0;
            ring_s2_r <= '0;
        end else begin
            ring_s1_r <= ring_pins;
            ring_s2_r <= ring_s1_r;
        end
    end

    // power-up reset places controller in reset, instruction at identification
    always_ff @(posedge jtag.tck or posedge rst) begin
        if (rst) begin
            state_r <= ST_RESET;
            ir_sh_r <= `OP_IDCODE;
            ir_r    <= `OP_IDCODE;
            byp_r   <= 1'b0;
            dr_r    <= '0;
        end else begin
            state_r <= state_nxt;
            ir_sh_r <= ir_sh_nxt;
            ir_r    <= ir_nxt;
            byp_r   <= byp_nxt;
            dr_r    <= dr_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Output side, falling edge
    always_comb begin
        oe_nxt  = (state_r == ST_SHIFT_DR) || (state_r == ST_SHIFT_IR);
        tdo_nxt = 1'b0;
        if (state_r == ST_SHIFT_IR) begin
            tdo_nxt = ir_sh_r[0];
        end else if (path_of(ir_r) == PATH_BYP) begin
            tdo_nxt = byp_r;
        end else begin
            tdo_nxt = dr_r[0];
        end
    end

    // outputs change on falling edge, float from reset
    always_ff @(negedge jtag.tck or posedge rst) begin
        if (rst) begin
            tdo_r <= 1'b0;
            oe_r  <= 1'b0;
        end else begin
            tdo_r <= tdo_nxt;
            oe_r  <= oe_nxt;
        end
    end

    assign jtag.tdo_o  = tdo_r;
    assign jtag.tdo_oe = oe_r;

    //////////////////////////////////////////////////////////////////////
    // all-zero and OP_SAMPLE_Z codes float memory outputs; level crosses into clk domain
    logic hiz_tck_r;
    always_ff @(posedge jtag.tck or posedge rst) begin
        if (rst) begin
            hiz_tck_r <= 1'b0;
        end else begin
            hiz_tck_r <= (ir_nxt == `OP_EXTEST) || (ir_nxt == `OP_SAMPLE_Z);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hiz_sync_r <= 2'h0;
        end else begin
            hiz_sync_r <= {hiz_sync_r[0], hiz_tck_r};
        end
    end
    assign mem_out_hiz = hiz_sync_r[1];
endmodule

// File: rtl/scan_host.sv
// External scan controller: divides its clock to make the test clock and runs shifts
`timescale 1ns/10ps
`include "tap_params.svh"
module scan_host
    import tap_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Request: TMS/TDI bit sequence, up to 32 edges
    input  wire logic       req_valid,
    input  wire logic [5:0] req_len,
    input  wire logic [31:0] req_tms,
    input  wire logic [31:0] req_tdi,
    input  wire logic       req_tlr,
    output logic            req_ready,
    // Answer: TDO bits captured on each rising test clock
    output logic            rsp_valid,
    output logic [31:0]     rsp_tdo,
    // Scan port
    tap_if.host             jtag
);
    //////////////////////////////////////////////////////////////////////
    host_state_t              st_r, st_nxt;
    logic [`TCK_DIV_W-1:0]    div_r, div_nxt;
    logic                     tck_r, tck_nxt;
    logic [5:0]               cnt_r, cnt_nxt;
    logic [31:0]              tms_r, tms_nxt, tdi_r, tdi_nxt, cap_r, cap_nxt;
    logic                     vld_r, vld_nxt;
    logic [1:0]               tdo_sync_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tdo_sync_r <= 2'h0;
        end else begin
            tdo_sync_r <= {tdo_sync_r[0], jtag.tdo};
        end
    end

    always_comb begin
        st_nxt  = st_r;
        div_nxt = div_r;
        tck_nxt = tck_r;
        cnt_nxt = cnt_r;
        tms_nxt = tms_r;
        tdi_nxt = tdi_r;
        cap_nxt = cap_r;
        vld_nxt = 1'b0;
        unique case (st_r)
            HC_IDLE: begin
                if (req_valid) begin
                    // exactly five high edges reset the far controller
                    cnt_nxt = req_tlr ? 6'(`RESET_TMS_EDGES - 1) : req_len;
                    tms_nxt = req_tlr ? 32'hFFFF_FFFF : req_tms;
                    tdi_nxt = req_tdi;
                    cap_nxt = 32'h0;
                    div_nxt = '0;
                    st_nxt  = HC_SHIFT;
                end
            end
            HC_SHIFT: begin
                div_nxt = div_r + 1'b1;
                if (div_r == `TCK_DIV_HALF - 1'b1) begin
                    div_nxt = '0;
                    tck_nxt = ~tck_r;
                    if (!tck_r) begin
                        cap_nxt = {tdo_sync_r[1], cap_r[31:1]};
                    end else begin
                        // Count on the falling edge so that a length of n gives n+1 edges
                        tms_nxt = {1'b0, tms_r[31:1]};
                        tdi_nxt = {1'b0, tdi_r[31:1]};
                        cnt_nxt = cnt_r - 1'b1;
                        if (cnt_r == 6'h0) begin
                            st_nxt = HC_DONE;
                        end
                    end
                end
            end
            HC_DONE: begin
                vld_nxt = 1'b1;
                st_nxt  = HC_IDLE;
            end
            HC_TLR:  st_nxt = HC_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r  <= HC_IDLE;
            div_r <= '0;
            tck_r <= 1'b0;
            cnt_r <= 6'h0;
            tms_r <= 32'hFFFF_FFFF;
            tdi_r <= 32'h0;
            cap_r <= 32'h0;
            vld_r <= 1'b0;
        end else begin
            st_r  <= st_nxt;
            div_r <= div_nxt;
            tck_r <= tck_nxt;
            cnt_r <= cnt_nxt;
            tms_r <= tms_nxt;
            tdi_r <= tdi_nxt;
            cap_r <= cap_nxt;
            vld_r <= vld_nxt;
        end
    end

    // test clock rests low while idle
    assign jtag.tck  = tck_r;
    assign jtag.tms  = tms_r[0];
    assign jtag.tdi  = tdi_r[0];
    assign req_ready = (st_r == HC_IDLE);
    assign rsp_valid = vld_r;
    assign rsp_tdo   = cap_r;
endmodule

// File: verification/tap_link_checker.sv
// Checker for the scan link between the memory's test port and the scan controller
`timescale 1ns/10ps
module tap_link_checker (
    // Memory side clock and reset
    input wire logic clk,
    input wire logic rst,
    // Scan link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo_o,
    input wire logic tdo_oe,
    input wire logic tdo
);
    ////////////////////////////////////////////////////////////////////////////////
    // Run of high mode edges; saturates so a long run never wraps back below five
    logic [2:0] ones_r;
    logic [2:0] ones_nxt;
    always_comb begin
        ones_nxt = !tms ? 3'h0 : ((ones_r == 3'h7) ? ones_r : ones_r + 3'h1);
    end
    always_ff @(posedge tck or posedge rst) begin
        if (rst) begin
            ones_r <= 3'h0;
        end else begin
            ones_r <= ones_nxt;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    chk_tdo_falling_only: assert property (@(posedge clk) disable iff (rst)
        tck |-> $stable(tdo_o) && $stable(tdo_oe)) else $error("data output moved while test clock high");
    chk_tms_tdi_hold: assert property (@(posedge clk) disable iff (rst)
        tck |-> $stable(tms) && $stable(tdi)) else $error("mode or data input moved while test clock high");
    chk_tck_half_period: assert property (@(posedge clk) disable iff (rst)
        $rose(tck) |-> tck [*4] ##1 !tck) else $error("test clock high phase not four cycles");
    chk_tck_reset_low: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> !tck && !tdo_oe && tdo) else $error("test clock or data output active after reset");
    chk_oe_needs_low_tms: assert property (@(posedge tck) disable iff (rst)
        tdo_oe |-> !$past(tms)) else $error("data output enabled outside a shift state");
    chk_oe_exit_shift: assert property (@(posedge tck) disable iff (rst)
        tdo_oe && tms |=> !tdo_oe) else $error("data output still enabled after leaving shift");
    chk_oe_shift_hold: assert property (@(posedge tck) disable iff (rst)
        tdo_oe && !tms |=> tdo_oe) else $error("data output dropped while still shifting");
    chk_tms_reset_quiet: assert property (@(negedge tck) disable iff (rst)
        ones_r >= 3'h5 |-> !tdo_oe) else $error("data output enabled after five high mode edges");
    cover_shift_start: cover property (@(posedge tck) disable iff (rst) $rose(tdo_oe));
    cover_five_ones: cover property (@(posedge tck) disable iff (rst) ones_r == 3'h5);
    cover_tck_pulse: cover property (@(posedge clk) disable iff (rst) $rose(tck));
endmodule

// File: verification/testbench.sv
// Self-checking bench: scan controller and memory test port joined over the scan link
`timescale 1ns/10ps
`include "tap_params.svh"
`define CHECK_EQ(act, exp, msg) begin compares++; if ((act) !== (exp)) begin n_fail++; \
    $display("unexpected at %0t: %s", $time, msg); end end
module testbench;
    import tap_pkg::*;
    logic        clk;
    logic        rst;
    logic        req_valid;
    logic [5:0]  req_len;
    logic [31:0] req_tms;
    logic [31:0] req_tdi;
    logic        req_tlr;
    logic        req_ready;
    logic        rsp_valid;
    logic [31:0] rsp_tdo;
    logic [15:0] ring_pins;
    logic        mem_out_hiz;
    int          n_fail;
    int          compares;
    int          cycles;
    tap_if jtag_bus ();
    sram_boundary_scan_tap sram_boundary_scan_tap_inst (.clk(clk), .rst(rst), .ring_pins(ring_pins),
        .jtag(jtag_bus), .mem_out_hiz(mem_out_hiz));
    scan_host scan_host_inst (.clk(clk), .rst(rst), .req_valid(req_valid), .req_len(req_len),
        .req_tms(req_tms), .req_tdi(req_tdi), .req_tlr(req_tlr), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_tdo(rsp_tdo), .jtag(jtag_bus));
    tap_link_checker tap_link_checker_inst (.clk(clk), .rst(rst), .tck(jtag_bus.tck), .tms(jtag_bus.tms),
        .tdi(jtag_bus.tdi), .tdo_o(jtag_bus.tdo_o), .tdo_oe(jtag_bus.tdo_oe), .tdo(jtag_bus.tdo));
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Whole run is about 2600 cycles; the ceiling leaves ample margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One controller request; called at a falling edge, request held until taken
    task automatic scan(input logic [5:0] len, input logic [31:0] tms, input logic [31:0] tdi,
                        input logic tlr, output logic [31:0] tdo);
        int w;
        w = 0;
        while (req_ready !== 1'b1 && w < 2000) begin
            @(negedge clk);
            w++;
        end
        req_len   = len;
        req_tms   = tms;
        req_tdi   = tdi;
        req_tlr   = tlr;
        req_valid = 1'b1;
        @(posedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        req_tlr   = 1'b0;
        w = 0;
        while (rsp_valid !== 1'b1 && w < 2000) begin
            @(negedge clk);
            w++;
        end
        `CHECK_EQ(rsp_valid, 1'b1, "no answer from controller")
        tdo = rsp_tdo;
    endtask
    // Idle to Shift-IR, three opcode bits, Update-IR, back to idle; returns captured low bits
    task automatic load_ir(input logic [2:0] op, output logic [1:0] cap);
        logic [31:0] t;
        scan(6'h08, 32'h0000_00C3, {25'h0, op, 4'h0}, 1'b0, t);
        cap = t[28:27];
    endtask
    // Idle to Shift-DR, n bits, Update-DR, back to idle
    task automatic dr_scan(input int n, input logic [31:0] tdi, output logic [31:0] q);
        logic [31:0] t;
        scan(6'h02, 32'h0000_0001, 32'h0, 1'b0, t);
        scan(6'(n - 1), 32'h1 << (n - 1), tdi, 1'b0, t);
        q = t >> (32 - n);
        scan(6'h01, 32'h0000_0001, 32'h0, 1'b0, t);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic [1:0]  cap;
        logic [2:0]  rsvd [3];
        logic [2:0]  hiz_ops [2];
        rsvd = '{`OP_RSVD_A, `OP_RSVD_B, `OP_RSVD_C};
        hiz_ops = '{`OP_EXTEST, `OP_SAMPLE_Z};
        rst = 1'b1;
        req_valid = 1'b0;
        req_len = 6'h00;
        req_tms = 32'h0;
        req_tdi = 32'h0;
        req_tlr = 1'b0;
        ring_pins = 16'h0000;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        `CHECK_EQ(jtag_bus.tdo_oe, 1'b0, "data output driven after reset")
        `CHECK_EQ(mem_out_hiz, 1'b0, "memory outputs floating after reset")
        scan(6'h00, 32'h0, 32'h0, 1'b0, q);
        dr_scan(32, 32'hFFFF_FFFF, q);
        `CHECK_EQ(q, `ID_CODE, "identification code after reset")
        $display("test reset_id done");
        load_ir(`OP_BYPASS, cap);
        `CHECK_EQ(cap, `IR_CAPTURE_LOW, "instruction capture pattern")
        dr_scan(8, 32'h0000_00A5, q);
        `CHECK_EQ(q, 32'h0000_004A, "bypass path one stage, cleared")
        foreach (rsvd[i]) begin
            load_ir(rsvd[i], cap);
            dr_scan(8, 32'h0000_003C, q);
            `CHECK_EQ(q, 32'h0000_0078, "reserved code path")
        end
        $display("test bypass done");
        ring_pins = 16'hC3A5;
        load_ir(`OP_SAMPLE, cap);
        `CHECK_EQ(mem_out_hiz, 1'b0, "sample floats memory outputs")
        dr_scan(24, 32'h0000_0096, q);
        `CHECK_EQ(q, 32'h0096_C3A5, "boundary capture then shift")
        ring_pins = 16'h0F0F;
        dr_scan(16, 32'h0000_FFFF, q);
        `CHECK_EQ(q, 32'h0000_0F0F, "update under sample changed capture")
        `CHECK_EQ(mem_out_hiz, 1'b0, "memory outputs after sample update")
        $display("test sample done");
        foreach (hiz_ops[i]) begin
            load_ir(hiz_ops[i], cap);
            `CHECK_EQ(mem_out_hiz, 1'b1, "memory outputs not floating")
            ring_pins = 16'h5AC3 ^ {13'h0, hiz_ops[i]};
            dr_scan(16, 32'h0, q);
            `CHECK_EQ(q, {16'h0, 16'h5AC3 ^ {13'h0, hiz_ops[i]}}, "capture under floating code")
        end
        load_ir(`OP_IDCODE, cap);
        `CHECK_EQ(mem_out_hiz, 1'b0, "floating kept after new instruction")
        $display("test floating done");
        load_ir(`OP_EXTEST, cap);
        // Park in Shift-DR so that reset needs all five high edges
        scan(6'h02, 32'h0000_0001, 32'h0, 1'b0, q);
        scan(6'h00, 32'h0, 32'h0, 1'b1, q);
        // Two-flop synchroniser on the memory side needs a few cycles to settle
        repeat (3) @(negedge clk);
        `CHECK_EQ(mem_out_hiz, 1'b0, "five high edges left instruction")
        scan(6'h00, 32'h0, 32'h0, 1'b0, q);
        dr_scan(32, 32'h0, q);
        `CHECK_EQ(q, `ID_CODE, "identification after five high edges")
        $display("test mode_reset done");
        give_verdict();
    end
endmodule
